// >>> rtl/hccg_pin_drv.sv
// host output pin formatter: active level, open-drain or push-pull, high impedance while disabled
module hccg_pin_drv (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // pin control
   input wire logic enable,
   input wire logic assertPin,
   input wire logic activeHigh,
   input wire logic openDrain,
   // pin
   output hccg_pkg::hccg_pin_type pin
);
   import hccg_pkg::*;

   hccg_pin_type s_r;
   hccg_pin_type s_nxt;
   logic level;

   // open drain only pulls low, so a high level is left to the pull-up
   always_comb begin
      level = assertPin ? activeHigh : ~activeHigh;
      s_nxt.out = level;
      s_nxt.oe = enable & (openDrain ? ~level : 1'b1);
   end

   // registered so the pin never glitches on a decode change
   always_ff @(posedge clock) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pin = s_r;
endmodule // hccg_pin_drv

// >>> rtl/hccg_pkg.sv
// types of the host to card cycle generator
package hccg_pkg;

   typedef enum logic [2:0] {
      HCCG_P600 = 3'h0,
      HCCG_P300 = 3'h1,
      HCCG_P250 = 3'h2,
      HCCG_P200 = 3'h3,
      HCCG_P150 = 3'h4,
      HCCG_P100 = 3'h5,
      HCCG_PRSV6 = 3'h6,
      HCCG_PRSV7 = 3'h7
   } hccg_profile_type;

   typedef enum logic [1:0] {
      HCCG_DEST_A = 2'h0,
      HCCG_DEST_B = 2'h1,
      HCCG_DEST_EXT = 2'h2,
      HCCG_DEST_RSV = 2'h3
   } hccg_dest_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_STROBE = 3'h2,
      ST_HOLD = 3'h3,
      ST_RELEASE = 3'h4,
      ST_RECOVER = 3'h5
   } hccg_fsm_type;

   typedef struct packed {
      logic select;
      logic readOrDir;
      logic writeOrStrobe;
   } hccg_host_in_type;

   typedef struct packed {
      logic slotAEnableLowN;
      logic slotAEnableHighN;
      logic slotBEnableLowN;
      logic slotBEnableHighN;
      logic externalDeviceSelect;
      logic attrSelectN;
      logic outputEnableN;
      logic ioReadN;
      logic addressLatchEnable;
      logic addressBufferEnableN;
      logic dataBufferEnableN;
      logic dataBufferDirection;
   } hccg_card_out_type;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hccg_cfg_req_type;

   typedef struct packed {
      logic out;
      logic oe;
   } hccg_pin_type;

   typedef struct packed {
      hccg_host_in_type hostSync1;
      hccg_host_in_type hostSync2;
      logic [1:0] waitSync1;
      logic [1:0] waitSync2;
      logic [7:0] hostLevel;
      logic [7:0] hostRole;
      logic [7:0] access;
      logic lock;
      logic [7:0] rdData;
      hccg_fsm_type fsm;
      logic [3:0] cnt;
      hccg_profile_type prof;
      hccg_dest_type dest;
      logic ioLike;
      logic ec;
      logic attr;
      hccg_card_out_type card;
   } hccg_core_type;

endpackage

// >>> rtl/hccg_regs.svh
// register offsets, field positions, reset values and cycle counts of the host to card cycle generator
`ifndef HCCG_REGS_SVH
`define HCCG_REGS_SVH

// register offsets on the configuration port
`define HCCG_OFS_HOST_LEVEL 8'h18
`define HCCG_OFS_HOST_ROLE 8'h19
`define HCCG_OFS_ACCESS 8'h1a
`define HCCG_OFS_STATUS 8'h1b
`define HCCG_OFS_GLOBAL_CONTROL 8'h1f

// host level register: active level per pin, driver structure, wait or acknowledge
`define HCCG_LVL_CS_HIGH 0
`define HCCG_LVL_RD_HIGH 1
`define HCCG_LVL_WR_HIGH 2
`define HCCG_LVL_WAITACK_HIGH 3
`define HCCG_LVL_INT_HIGH 4
`define HCCG_LVL_WAITACK_OD 5
`define HCCG_LVL_INT_OD 6
`define HCCG_LVL_ACK_MODE 7

// host role register
`define HCCG_ROLE_READ_PIN 0
`define HCCG_ROLE_WRITE_PIN 1

// access register
`define HCCG_ACC_PROF_LSB 0
`define HCCG_ACC_DEST_LSB 3
`define HCCG_ACC_ATTR 5
`define HCCG_ACC_IO 6
`define HCCG_ACC_EC 7

// global control register
`define HCCG_GC_LOCK 0

// reset values
`define HCCG_RST_HOST_LEVEL 8'h00
`define HCCG_RST_HOST_ROLE 8'h00
`define HCCG_RST_ACCESS 8'h00

// card enable to read strobe, in clock cycles
`define HCCG_T3_600 4'h3
`define HCCG_T3_MEM 4'h1
`define HCCG_T3_IO 4'h2
// read strobe phase, in clock cycles
`define HCCG_T4_600 4'he
`define HCCG_T4_300 4'h8
`define HCCG_T4_250 4'h7
`define HCCG_T4_200 4'h5
`define HCCG_T4_150 4'h4
`define HCCG_T4_100 4'h3
`define HCCG_T4_IO 4'h3
// minimum strobe hold after the strobe phase
`define HCCG_T5_MEM 4'h0
`define HCCG_T5_IO 4'h2
// data buffer recovery after strobe release
`define HCCG_T10_600 4'h5
`define HCCG_T10_MID 4'h3
`define HCCG_T10_100 4'h2
`define HCCG_T10_IO 4'h2

`endif

// >>> rtl/hccg_top.sv
// host to card read cycle generator with configuration registers and lock
`include "hccg_regs.svh"

module hccg_top (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // configuration register port
   input wire hccg_pkg::hccg_cfg_req_type cfgReq,
   output logic [7:0] cfgReadData,
   // host bus pins
   input wire hccg_pkg::hccg_host_in_type hostIn,
   input wire logic interruptRequest,
   output hccg_pkg::hccg_pin_type waitAckPin,
   output hccg_pkg::hccg_pin_type interruptPin,
   output logic hostReadActive,
   output logic hostWriteActive,
   // card slot pins
   input wire logic slotAWaitInN,
   input wire logic slotBWaitInN,
   output hccg_pkg::hccg_card_out_type cardOut,
   output logic cardDriveEnable
);
   import hccg_pkg::*;

   // idle levels of the card side, matching the pin reset states
   localparam hccg_card_out_type CARD_IDLE = '{
      slotAEnableLowN: 1'b1,
      slotAEnableHighN: 1'b1,
      slotBEnableLowN: 1'b1,
      slotBEnableHighN: 1'b1,
      externalDeviceSelect: 1'b0,
      attrSelectN: 1'b1,
      outputEnableN: 1'b1,
      ioReadN: 1'b1,
      addressLatchEnable: 1'b1,
      addressBufferEnableN: 1'b1,
      dataBufferEnableN: 1'b1,
      dataBufferDirection: 1'b0
   };

   localparam hccg_core_type CORE_RESET = '{
      hostLevel: `HCCG_RST_HOST_LEVEL,
      hostRole: `HCCG_RST_HOST_ROLE,
      access: `HCCG_RST_ACCESS,
      fsm: ST_IDLE,
      prof: HCCG_P600,
      dest: HCCG_DEST_A,
      card: CARD_IDLE,
      default: '0
   };

   hccg_core_type s_r;
   hccg_core_type s_nxt;

   logic csAct;
   logic rdPin;
   logic wrPin;
   logic rdAct;
   logic wrAct;
   logic modWait;
   logic waitAckAssert;
   logic ceOn;
   logic strobeOn;
   hccg_fsm_type fsmNxt;
   hccg_profile_type profNew;

   // true when a sampled pin sits at its configured active level
   function automatic logic pinActive(input logic value, input logic activeHigh);
      pinActive = ~(value ^ activeHigh);
   endfunction

   // fall back to the slowest profile for a profile that the space does not offer
   function automatic hccg_profile_type legalProfile(input logic [2:0] code, input logic attr);
      hccg_profile_type p;
      p = hccg_profile_type'(code);
      if (attr) begin
         legalProfile = (p == HCCG_P300) ? HCCG_P300 : HCCG_P600;
      end else if (p == HCCG_P300 || p == HCCG_PRSV6 || p == HCCG_PRSV7) begin
         legalProfile = HCCG_P600;
      end else begin
         legalProfile = p;
      end
   endfunction

   // cycles from card enable to read strobe
   function automatic logic [3:0] ceToStrobe(input hccg_profile_type p, input logic ioLike);
      if (ioLike) begin
         ceToStrobe = `HCCG_T3_IO;
      end else if (p == HCCG_P600) begin
         ceToStrobe = `HCCG_T3_600;
      end else begin
         ceToStrobe = `HCCG_T3_MEM;
      end
   endfunction

   // cycles of the read strobe phase before any module wait
   function automatic logic [3:0] strobeLen(input hccg_profile_type p, input logic ioLike);
      if (ioLike) begin
         strobeLen = `HCCG_T4_IO;
      end else begin
         case (p)
            HCCG_P300: strobeLen = `HCCG_T4_300;
            HCCG_P250: strobeLen = `HCCG_T4_250;
            HCCG_P200: strobeLen = `HCCG_T4_200;
            HCCG_P150: strobeLen = `HCCG_T4_150;
            HCCG_P100: strobeLen = `HCCG_T4_100;
            default: strobeLen = `HCCG_T4_600;
         endcase
      end
   endfunction

   // cycles that the data buffers stay off after strobe release
   function automatic logic [3:0] recoverLen(input hccg_profile_type p, input logic ioLike);
      if (ioLike) begin
         recoverLen = `HCCG_T10_IO;
      end else if (p == HCCG_P600) begin
         recoverLen = `HCCG_T10_600;
      end else if (p == HCCG_P100) begin
         recoverLen = `HCCG_T10_100;
      end else begin
         recoverLen = `HCCG_T10_MID;
      end
   endfunction

   // decode of the synchronised host pins into active read and write
   always_comb begin
      csAct = pinActive(s_r.hostSync2.select, s_r.hostLevel[`HCCG_LVL_CS_HIGH]);
      rdPin = pinActive(s_r.hostSync2.readOrDir, s_r.hostLevel[`HCCG_LVL_RD_HIGH]);
      wrPin = pinActive(s_r.hostSync2.writeOrStrobe, s_r.hostLevel[`HCCG_LVL_WR_HIGH]);
      // in the read pin role, direction pin active means a read and the strobe pin qualifies it; otherwise the read pin alone
      if (s_r.hostRole[`HCCG_ROLE_READ_PIN]) begin
         rdAct = csAct & wrPin & rdPin;
      end else begin
         rdAct = csAct & rdPin;
      end
      if (s_r.hostRole[`HCCG_ROLE_WRITE_PIN]) begin
         wrAct = csAct & wrPin & ~rdPin;
      end else begin
         wrAct = csAct & wrPin;
      end
      // nothing from the host counts until the port is locked
      rdAct = rdAct & s_r.lock;
      wrAct = wrAct & s_r.lock;
   end

   // wait from the addressed module; the external device has none
   always_comb begin
      case (s_r.dest)
         HCCG_DEST_A: modWait = ~s_r.waitSync2[0];
         HCCG_DEST_B: modWait = ~s_r.waitSync2[1];
         default: modWait = 1'b0;
      endcase
   end

   // next state: synchronisers, registers, read cycle sequencer, card pins
   always_comb begin
      s_nxt = s_r;
      fsmNxt = s_r.fsm;
      profNew = legalProfile(s_r.access[`HCCG_ACC_PROF_LSB +: 3], s_r.access[`HCCG_ACC_ATTR]);
      // two flops before the decode; the first stage is read by the second alone
      s_nxt.hostSync1 = hostIn;
      s_nxt.hostSync2 = s_r.hostSync1;
      s_nxt.waitSync1 = {slotBWaitInN, slotAWaitInN};
      s_nxt.waitSync2 = s_r.waitSync1;

      // configuration writes; host pin setup freezes once locked
      if (cfgReq.write) begin
         case (cfgReq.addr)
            `HCCG_OFS_HOST_LEVEL: begin
               if (!s_r.lock) begin
                  s_nxt.hostLevel = cfgReq.wdata;
               end
            end
            `HCCG_OFS_HOST_ROLE: begin
               if (!s_r.lock) begin
                  s_nxt.hostRole = cfgReq.wdata;
               end
            end
            `HCCG_OFS_ACCESS: s_nxt.access = cfgReq.wdata;
            `HCCG_OFS_GLOBAL_CONTROL: begin
               // set only; a reset is the one way back to the unlocked state
               if (cfgReq.wdata[`HCCG_GC_LOCK]) begin
                  s_nxt.lock = 1'b1;
               end
            end
            default: s_nxt.lock = s_r.lock;
         endcase
      end

      // registered read data, zero for unmapped offsets
      s_nxt.rdData = 8'h00;
      if (cfgReq.read) begin
         case (cfgReq.addr)
            `HCCG_OFS_HOST_LEVEL: s_nxt.rdData = s_r.hostLevel;
            `HCCG_OFS_HOST_ROLE: s_nxt.rdData = s_r.hostRole;
            `HCCG_OFS_ACCESS: s_nxt.rdData = s_r.access;
            `HCCG_OFS_STATUS: s_nxt.rdData = {3'h0, wrAct, rdAct, s_r.fsm};
            `HCCG_OFS_GLOBAL_CONTROL: s_nxt.rdData = {7'h00, s_r.lock};
            default: s_nxt.rdData = 8'h00;
         endcase
      end

      // read cycle sequencer; the access kind is caught at start so later
      // register writes cannot disturb a cycle in flight
      unique case (s_r.fsm)
         ST_IDLE: begin
            if (rdAct) begin
               fsmNxt = ST_SETUP;
               s_nxt.prof = profNew;
               s_nxt.dest = hccg_dest_type'(s_r.access[`HCCG_ACC_DEST_LSB +: 2]);
               s_nxt.ec = s_r.access[`HCCG_ACC_EC];
               s_nxt.attr = s_r.access[`HCCG_ACC_ATTR];
               s_nxt.ioLike = s_r.access[`HCCG_ACC_IO] | s_r.access[`HCCG_ACC_EC]
                  | (s_r.access[`HCCG_ACC_DEST_LSB +: 2] == HCCG_DEST_EXT);
               s_nxt.cnt = ceToStrobe(profNew, s_r.access[`HCCG_ACC_IO] | s_r.access[`HCCG_ACC_EC]
                  | (s_r.access[`HCCG_ACC_DEST_LSB +: 2] == HCCG_DEST_EXT)) - 4'h1;
            end
         end
         ST_SETUP: begin
            // card enable is on; count down to the strobe
            if (s_r.cnt == 4'h0) begin
               fsmNxt = ST_STROBE;
               s_nxt.cnt = strobeLen(s_r.prof, s_r.ioLike) - 4'h1;
            end else begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end
         end
         ST_STROBE: begin
            if (modWait) begin
               s_nxt.cnt = s_r.cnt;
            end else if (s_r.cnt == 4'h0) begin
               fsmNxt = ST_HOLD;
               s_nxt.cnt = s_r.ioLike ? `HCCG_T5_IO : `HCCG_T5_MEM;
            end else begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end
         end
         ST_HOLD: begin
            // strobe held for the minimum, then until the host has ended and
            // the data bus is already isolated
            if (s_r.cnt != 4'h0) begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end else if (!rdAct && s_r.card.dataBufferEnableN) begin
               fsmNxt = ST_RELEASE;
               s_nxt.cnt = recoverLen(s_r.prof, s_r.ioLike) - 4'h1;
            end
         end
         ST_RELEASE: begin
            fsmNxt = ST_RECOVER;
            s_nxt.cnt = s_r.cnt - 4'h1;
         end
         ST_RECOVER: begin
            // a new start is held off here, which delays its card enable
            if (s_r.cnt == 4'h0) begin
               fsmNxt = ST_IDLE;
            end else begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end
         end
         default: fsmNxt = ST_IDLE;
      endcase
      s_nxt.fsm = fsmNxt;

      // card pins follow the next state so every pin leaves a flop
      ceOn = (fsmNxt == ST_SETUP) | (fsmNxt == ST_STROBE) | (fsmNxt == ST_HOLD) | (fsmNxt == ST_RELEASE);
      strobeOn = (fsmNxt == ST_STROBE) | (fsmNxt == ST_HOLD);
      s_nxt.card = CARD_IDLE;
      if (ceOn) begin
         unique case (s_nxt.dest)
            HCCG_DEST_A: begin
               s_nxt.card.slotAEnableLowN = s_nxt.ec;
               s_nxt.card.slotAEnableHighN = ~s_nxt.ec;
            end
            HCCG_DEST_B: begin
               s_nxt.card.slotBEnableLowN = s_nxt.ec;
               s_nxt.card.slotBEnableHighN = ~s_nxt.ec;
            end
            HCCG_DEST_EXT: s_nxt.card.externalDeviceSelect = 1'b1;
            HCCG_DEST_RSV: s_nxt.card.externalDeviceSelect = 1'b0;
         endcase
         s_nxt.card.attrSelectN = ~((s_nxt.attr | (s_nxt.ioLike & ~s_nxt.ec))
            & (s_nxt.dest != HCCG_DEST_EXT));
         s_nxt.card.addressBufferEnableN = 1'b0;
      end
      if (strobeOn) begin
         s_nxt.card.outputEnableN = s_nxt.ioLike;
         s_nxt.card.ioReadN = ~s_nxt.ioLike;
         // isolate first, turn the direction back one cycle later
         s_nxt.card.dataBufferEnableN = ~rdAct;
         s_nxt.card.dataBufferDirection = rdAct | ~s_r.card.dataBufferEnableN;
      end
      // address held while the host samples data, freed with the card enable
      s_nxt.card.addressLatchEnable = ~((fsmNxt == ST_HOLD) | (fsmNxt == ST_RELEASE));
   end

   // single state register of the block
   always_ff @(posedge clock) begin
      if (reset) begin
         s_r <= CORE_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // wait is driven from the synchronised start, ahead of the sequencer;
   // ack is given only in the hold phase after the strobe phase; the next
   // state is used so the registered pin turns on the same edge as the latch
   always_comb begin
      if (s_r.hostLevel[`HCCG_LVL_ACK_MODE]) begin
         waitAckAssert = rdAct & (fsmNxt == ST_HOLD);
      end else begin
         waitAckAssert = rdAct & (fsmNxt != ST_HOLD);
      end
   end

   // wait or acknowledge pin, high impedance until locked
   hccg_pin_drv waitAckDrv (
      .clock(clock),
      .reset(reset),
      .enable(s_r.lock),
      .assertPin(waitAckAssert),
      .activeHigh(s_r.hostLevel[`HCCG_LVL_WAITACK_HIGH]),
      .openDrain(s_r.hostLevel[`HCCG_LVL_WAITACK_OD]),
      .pin(waitAckPin)
   );

   // interrupt pin, high impedance until locked
   hccg_pin_drv interruptDrv (
      .clock(clock),
      .reset(reset),
      .enable(s_r.lock),
      .assertPin(interruptRequest),
      .activeHigh(s_r.hostLevel[`HCCG_LVL_INT_HIGH]),
      .openDrain(s_r.hostLevel[`HCCG_LVL_INT_OD]),
      .pin(interruptPin)
   );

   // outputs
   assign cfgReadData = s_r.rdData;
   assign cardOut = s_r.card;
   assign cardDriveEnable = s_r.lock;
   assign hostReadActive = rdAct;
   assign hostWriteActive = wrAct;
endmodule // hccg_top

// >>> tb/hccg_card_model.sv
// card module model: answers a read strobe promptly or with wait cycles
module hccg_card_model (
   // clock
   input wire logic clock,
   // card strobe and requested stretch
   input wire logic strobeN,
   input wire logic [3:0] stretch,
   // module wait, active low
   output logic waitN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic strobeLast_r = 1'b1;
   logic [3:0] cnt_r = 4'h0;
   // wait starts one cycle into the strobe; idle level is high like the pulled-up line
   always_ff @(posedge clock) begin
      strobeLast_r <= strobeN;
      if (strobeLast_r && !strobeN) begin
         cnt_r <= stretch;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
   assign waitN = (cnt_r == 4'h0);
endmodule // hccg_card_model

// >>> tb/hccg_checker.sv
// port assertions of the host to card cycle generator
module hccg_checker (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // config and host side
   input wire hccg_pkg::hccg_cfg_req_type cfgReq,
   input wire logic [7:0] cfgReadData,
   input wire hccg_pkg::hccg_host_in_type hostIn,
   input wire logic interruptRequest,
   input wire hccg_pkg::hccg_pin_type waitAckPin,
   input wire hccg_pkg::hccg_pin_type interruptPin,
   input wire logic hostReadActive,
   input wire logic hostWriteActive,
   // card side
   input wire logic slotAWaitInN,
   input wire logic slotBWaitInN,
   input wire hccg_pkg::hccg_card_out_type cardOut,
   input wire logic cardDriveEnable
);
   import hccg_pkg::*;
   logic anyEn;
   logic strobeOff;
   // summaries shared by several properties
   assign anyEn = ~&{cardOut.slotAEnableLowN, cardOut.slotAEnableHighN, cardOut.slotBEnableLowN,
      cardOut.slotBEnableHighN} | cardOut.externalDeviceSelect;
   assign strobeOff = cardOut.outputEnableN & cardOut.ioReadN;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   a_quiet_unlocked: assert property (!cardDriveEnable |-> !waitAckPin.oe && !interruptPin.oe)
      else $error("host pin driven before lock");
   a_idle_unlocked: assert property (!cardDriveEnable |-> !hostReadActive && !hostWriteActive && strobeOff)
      else $error("host cycle accepted before lock");
   a_oe_after_en: assert property ($fell(cardOut.outputEnableN) |-> $past(anyEn))
      else $error("output enable before card enable");
   a_io_lag: assert property ($fell(cardOut.ioReadN) |-> $past(anyEn, 2) && !$past(anyEn, 3))
      else $error("io read lag wrong");
   a_dir_turn: assert property (!strobeOff |-> cardOut.dataBufferDirection)
      else $error("buffer direction not toward host");
   a_isolate_first: assert property ($rose(strobeOff) |-> $past(cardOut.dataBufferEnableN))
      else $error("strobe released before isolation");
   a_release_after: assert property ($rose(strobeOff) |-> anyEn ##1 (!anyEn && cardOut.attrSelectN &&
      cardOut.addressLatchEnable)) else $error("enable release timing wrong");
   a_ale_hold: assert property ($fell(cardOut.addressLatchEnable) |-> !strobeOff)
      else $error("address latched outside strobe");
   a_one_strobe: assert property (cardOut.outputEnableN || cardOut.ioReadN)
      else $error("both read strobes active");
   a_mem_phase: assert property ($fell(cardOut.outputEnableN) |=> !cardOut.outputEnableN [*2])
      else $error("memory strobe too short");
   a_buf_rest: assert property ($rose(strobeOff) |-> cardOut.dataBufferEnableN [*3])
      else $error("data buffer enabled too soon");
   a_ext_attr: assert property (cardOut.externalDeviceSelect |-> cardOut.attrSelectN)
      else $error("attribute select on external cycle");
   // main scenarios reached
   c_mem_read: cover property ($fell(cardOut.outputEnableN));
   c_io_read: cover property ($fell(cardOut.ioReadN));
   c_stretched: cover property (!cardOut.outputEnableN && !slotAWaitInN);
endmodule // hccg_checker

bind hccg_top hccg_checker i_hccg_checker (.clock(clock), .reset(reset), .cfgReq(cfgReq),
   .cfgReadData(cfgReadData), .hostIn(hostIn), .interruptRequest(interruptRequest),
   .waitAckPin(waitAckPin), .interruptPin(interruptPin), .hostReadActive(hostReadActive),
   .hostWriteActive(hostWriteActive), .slotAWaitInN(slotAWaitInN), .slotBWaitInN(slotBWaitInN),
   .cardOut(cardOut), .cardDriveEnable(cardDriveEnable));

// >>> tb/test_host_to_card_cycle_generator.sv
// self-checking bench of the host to card cycle generator
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
$display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_host_to_card_cycle_generator;
   timeunit 1ns;
   timeprecision 1ns;
   import hccg_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   hccg_cfg_req_type cfgReq = '0;
   hccg_host_in_type hostIn = '0;
   logic interruptRequest = 1'b0;
   logic [3:0] stretch = 4'h0;
   logic waitN;
   logic [7:0] cfgReadData;
   hccg_pin_type waitAckPin, interruptPin;
   logic hostReadActive, hostWriteActive, cardDriveEnable;
   hccg_card_out_type cardOut;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [7:0] lvl;
   logic [2:0] hRd;
   int t4Tab[6] = '{14, 8, 7, 5, 4, 3};
   logic [7:0] accTab[10] = '{8'h00, 8'h21, 8'h0a, 8'h03, 8'h0c, 8'h05, 8'h40, 8'h88, 8'h10, 8'h01};
   wire logic [3:0] actEn = ~{cardOut.slotAEnableLowN, cardOut.slotAEnableHighN, cardOut.slotBEnableLowN,
      cardOut.slotBEnableHighN};

   // 25 MHz clock
   always #20 clock = ~clock;

   hccg_top i_hccg_top (.clock(clock), .reset(reset), .cfgReq(cfgReq), .cfgReadData(cfgReadData),
      .hostIn(hostIn), .interruptRequest(interruptRequest), .waitAckPin(waitAckPin),
      .interruptPin(interruptPin), .hostReadActive(hostReadActive), .hostWriteActive(hostWriteActive),
      .slotAWaitInN(waitN), .slotBWaitInN(waitN), .cardOut(cardOut), .cardDriveEnable(cardDriveEnable));
   hccg_card_model i_hccg_card_model (.clock(clock), .strobeN(cardOut.outputEnableN & cardOut.ioReadN),
      .stretch(stretch), .waitN(waitN));

   task end_of_test();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // one-cycle register request; read data is looked at the cycle after
   task cfg(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge clock) cfgReq <= '{write: wr, read: !wr, addr: a, wdata: d};
      @(negedge clock) cfgReq <= '0;
   endtask

   task rdchk(input logic [7:0] a, input logic [7:0] e);
      cfg(1'b0, a, 8'h00);
      `CHK(cfgReadData, e)
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return |actEn | cardOut.externalDeviceSelect;
         1: return !(cardOut.outputEnableN & cardOut.ioReadN);
         2: return !cardOut.addressLatchEnable;
         default: return cardOut.outputEnableN & cardOut.ioReadN;
      endcase
   endfunction

   // bounded wait on a card event, counting edges
   task wait_sig(input int k, output int n);
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (!sig(k) && n < 40);
      `CHK(sig(k), 1'b1)
   endtask

   // one read, expectations worked out from the access byte
   task rd(input logic [7:0] acc);
      int p, io, t3, t4, n, w;
      logic [3:0] en;
      p = acc[2:0];
      io = acc[6] | acc[7] | (acc[4:3] == 2'h2);
      if (p > 5 || (acc[5] && p > 1) || (!acc[5] && p == 1)) p = 0;
      t3 = io ? 2 : (p == 0 ? 3 : 1);
      t4 = io ? 3 : t4Tab[p];
      w = (!io && p == 0) ? $urandom % 4 : 0;
      en = acc[4] ? 4'h0 : 4'h8 >> (2 * acc[3] + acc[7]);
      cfg(1'b1, 8'h1a, acc);
      @(negedge clock) stretch <= w[3:0];
      hostIn <= hRd;
      wait_sig(0, n);
      `CHK(n inside {[3:7]}, 1'b1)
      wait_sig(1, n);
      `CHK(n, t3)
      `CHK({actEn, cardOut.externalDeviceSelect}, {en, acc[4]})
      `CHK(~cardOut.attrSelectN, (acc[5] | acc[6]) & ~acc[7] & ~acc[4])
      `CHK({cardOut.outputEnableN, cardOut.ioReadN}, io ? 2'b10 : 2'b01)
      `CHK({cardOut.addressBufferEnableN, cardOut.dataBufferEnableN, cardOut.dataBufferDirection}, 3'b001)
      `CHK(waitAckPin.out, lvl[3] ^ lvl[7])
      wait_sig(2, n);
      `CHK(n, t4 + w)
      repeat (2) @(posedge clock);
      #1;
      `CHK(waitAckPin, {~(lvl[3] ^ lvl[7]), ~lvl[5] | (lvl[3] ^ lvl[7])})
      @(negedge clock) hostIn <= 3'b000;
      wait_sig(3, n);
      `CHK(n <= 5, 1'b1)
      repeat (12) @(posedge clock);
   endtask

   // main sequence: two host configurations, each after its own reset
   initial begin
      void'($urandom(91925));
      for (int pass = 0; pass < 2; pass++) begin
         // second pass turns both outputs active high and open drain
         lvl = pass ? 8'hff : 8'h07;
         hRd = pass ? 3'b111 : 3'b110;
         @(negedge clock) reset <= 1'b1;
         repeat (5) @(negedge clock);
         reset <= 1'b0;
         `CHK(cardOut, 12'hf7e)
         `CHK({waitAckPin.oe, interruptPin.oe, cfgReadData}, 10'h000)
         cfg(1'b1, 8'h18, lvl);
         cfg(1'b1, 8'h19, {6'h00, {2{pass[0]}}});
         @(negedge clock) hostIn <= hRd;
         repeat (6) @(negedge clock);
         `CHK({hostReadActive, cardDriveEnable, cardOut}, {2'b00, 12'hf7e})
         hostIn <= 3'b000;
         repeat (3) @(negedge clock);
         cfg(1'b1, 8'h1f, 8'h01);
         cfg(1'b1, 8'h18, 8'h40);
         rdchk(8'h18, lvl);
         rdchk(8'h1f, 8'h01);
         rdchk(8'h30, 8'h00);
         `CHK(cardDriveEnable, 1'b1)
         @(negedge clock) hostIn <= 3'b101;
         interruptRequest <= 1'b1;
         repeat (3) @(negedge clock);
         `CHK({hostWriteActive, hostReadActive, interruptPin}, {2'b10, lvl[4], ~lvl[6]})
         rdchk(8'h1b, 8'h10);
         hostIn <= 3'b000;
         interruptRequest <= 1'b0;
         repeat (12) @(negedge clock);
         foreach (accTab[i]) rd(accTab[i]);
      end
      end_of_test();
   end

   // watchdog against a hang
   initial begin
      repeat (10000) @(posedge clock);
      n_mismatch++;
      end_of_test();
   end
endmodule // test_host_to_card_cycle_generator
